// File: hdl/baseband_rtp_segmenter.sv
// Baseband structure to RTP multicast packet segmenter with its FIFO
//
// Summary of operation
// [R1] Timestamp: 22 seconds LSBs, nanoseconds bits 20-29
// [R2] Destination 239.0.51.48, port 30000 plus pipe
// [R3] Marker set only on first packet of set
// [R4] Same timestamp on every packet of set
// [R5] SSRC is byte length first, else zero
// [R6] Payload type is always 78
// [R7] CSRC count is always zero
// [R8] Extension bit set only when signing extension present
// [R9] Padding and sequence follow base RTP protocol
// [R10] Payloads are contiguous fragments forming one set
// [R11] Segment complete structures; each packet fits MTU
// [R12] Receiver resequences packets by sequence number (the consumer model does not reorder; any out-of-order number is a gap)
// [R13] Receiver accumulates until SSRC byte count reached
// [R14] Receiver discards structure on gap or early marker
// [R15] Nanoseconds within 999,999,999; seconds are 32 LSBs
// [R16] After discard receiver waits for next marker
// [R17] Sequence number per pipe increments, wraps 65536
// [R18] Receiver flags an error on each discard
`timescale 1ns/100ps
`include "bb_seg_regs.svh"

// ----------------------------------------------------------------
// Byte FIFO with registered flags
// ----------------------------------------------------------------
module bb_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic in_valid, // Write request
	output logic in_ready, // Room for one word
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Word available
	input wire logic out_ready, // Read request
	output logic [WIDTH-1:0] out_data // Oldest word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	assign out_data = mem[rd_ptr];

	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers, fill level and flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
			count <= next_count;
			in_ready <= next_count < (AW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end
endmodule : bb_byte_fifo

// ----------------------------------------------------------------
// Segmenter top
// ----------------------------------------------------------------
module baseband_rtp_segmenter (
	input wire logic SYS_CLK, // 40 MHz system clock
	input wire logic ARST_N, // Asynchronous reset, active low
	input wire logic DESC_VALID, // Complete structure announced
	input wire bb_seg_pkg::desc_t DESC, // Length, time, pipe, signing
	output logic DESC_READY, // Descriptor accepted when high
	input wire logic IN_VALID, // Structure byte valid
	input wire logic [7:0] IN_DATA, // Structure byte
	output logic IN_READY, // FIFO has room
	output logic OUT_VALID, // Payload byte valid
	output bb_seg_pkg::beat_t OUT_BEAT, // Payload byte and packet bounds
	input wire logic OUT_READY, // Consumer takes byte
	output bb_seg_pkg::hdr_t OUT_HDR // Header of current packet
);
	bb_seg_pkg::seg_state_t state;
	bb_seg_pkg::desc_t desc_q;
	logic [31:0] total_left;
	logic [15:0] pkt_left;
	logic first_pkt;
	logic beat_first;
	logic [15:0] seq_tab [64];
	logic fifo_valid;
	logic [7:0] fifo_data;

	// Frame identification from emission time
	function automatic logic [31:0] frame_ts(input logic [31:0] sec,
		input logic [31:0] ns);
		frame_ts = {sec[`BB_SEC_BITS-1:0], ns[`BB_NS_HI:`BB_NS_LO]};
	endfunction : frame_ts

	// ------------------------------------------------------------
	// Segment sizing and handshake decode
	// ------------------------------------------------------------
	wire [15:0] max_pay = desc_q.signed_ext ? `BB_PAY_SIGNED : `BB_PAY_PLAIN;
	wire [15:0] seg_len = (total_left < {16'h0, max_pay}) ?
		total_left[15:0] : max_pay; // see [R11]
	wire [15:0] cur_seq = seq_tab[desc_q.pipe];
	wire desc_take = DESC_VALID && DESC_READY;
	wire head_go = (state == bb_seg_pkg::ST_HEAD) && !OUT_VALID;
	wire take_byte = (state == bb_seg_pkg::ST_DATA) && fifo_valid &&
		(!OUT_VALID || OUT_READY);
	wire pkt_end = take_byte && (pkt_left == 16'h0001);
	wire set_end = pkt_end && (total_left == 32'h0000_0001);
	wire [31:0] ns_in = (DESC.nanosec > `BB_NS_MAX) ?
		`BB_NS_MAX : DESC.nanosec; // see [R15]

	// Structure bytes wait here until the segmenter drains them
	bb_byte_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
		.clk(SYS_CLK),
		.rst_n(ARST_N),
		.in_valid(IN_VALID),
		.in_ready(IN_READY),
		.in_data(IN_DATA),
		.out_valid(fifo_valid),
		.out_ready(take_byte),
		.out_data(fifo_data)
	);

	// ------------------------------------------------------------
	// Sequencing of one segment set
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= bb_seg_pkg::ST_IDLE;
			DESC_READY <= 1'b1;
			desc_q <= '0;
			total_left <= '0;
			pkt_left <= '0;
			first_pkt <= 1'b0;
		end else begin
			case (state)
				bb_seg_pkg::ST_IDLE: begin
					if (desc_take) begin // see [R11]
						desc_q <= DESC;
						desc_q.nanosec <= ns_in;
						total_left <= DESC.length;
						first_pkt <= 1'b1;
						if (DESC.length != 32'h0) begin
							DESC_READY <= 1'b0;
							state <= bb_seg_pkg::ST_HEAD;
						end
					end
				end
				bb_seg_pkg::ST_HEAD: begin
					if (head_go) begin
						pkt_left <= seg_len;
						state <= bb_seg_pkg::ST_DATA;
					end
				end
				bb_seg_pkg::ST_DATA: begin
					if (take_byte) begin // see [R10]
						pkt_left <= pkt_left - 16'h0001;
						total_left <= total_left - 32'h0000_0001;
					end
					if (pkt_end) begin
						first_pkt <= 1'b0;
						state <= set_end ? bb_seg_pkg::ST_IDLE :
							bb_seg_pkg::ST_HEAD;
						DESC_READY <= set_end;
					end
				end
				default: begin
					state <= bb_seg_pkg::ST_IDLE;
					DESC_READY <= 1'b1;
				end
			endcase
		end
	end

	// Per-pipe sequence counters, advanced once per packet
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < 64; i++) begin
				seq_tab[i] <= '0;
			end
		end else if (head_go) begin
			seq_tab[desc_q.pipe] <= cur_seq + 16'h0001; // see [R17]
		end
	end

	// ------------------------------------------------------------
	// Header built at the start of each packet
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			OUT_HDR <= '0;
		end else if (head_go) begin
			OUT_HDR.dst_addr <= `BB_MCAST_ADDR; // see [R2]
			OUT_HDR.dst_port <= `BB_PORT_BASE +
				{10'h0, desc_q.pipe}; // see [R2]
			OUT_HDR.version <= `BB_RTP_VERSION;
			OUT_HDR.padding <= `BB_PADDING; // see [R9]
			OUT_HDR.extension <= desc_q.signed_ext; // see [R8]
			OUT_HDR.csrc_count <= `BB_CSRC_COUNT; // see [R7]
			OUT_HDR.marker <= first_pkt; // see [R3]
			OUT_HDR.payload_type <= `BB_PAYLOAD_TYPE; // see [R6]
			OUT_HDR.seq_num <= cur_seq; // see [R9]
			OUT_HDR.timestamp <= frame_ts(desc_q.seconds,
				desc_q.nanosec); // see [R1] see [R4]
			OUT_HDR.ssrc <= first_pkt ? desc_q.length : 32'h0; // see [R5]
			OUT_HDR.payload_len <= seg_len; // see [R11]
		end
	end

	// First-byte marker for the packet in progress
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			beat_first <= 1'b0;
		end else if (head_go) begin
			beat_first <= 1'b1;
		end else if (take_byte) begin
			beat_first <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Output byte register
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			OUT_VALID <= 1'b0;
			OUT_BEAT <= '0;
		end else if (take_byte) begin
			OUT_VALID <= 1'b1;
			OUT_BEAT <= '{data: fifo_data, first: beat_first,
				last: pkt_left == 16'h0001}; // see [R10]
		end else if (OUT_READY) begin
			OUT_VALID <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_TIMESTAMP: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		head_go |=> OUT_HDR.timestamp == frame_ts($past(desc_q.seconds),
		$past(desc_q.nanosec))) // see [R1]
		else $error("Timestamp does not match frame time");
	AST_DEST: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		OUT_VALID |-> OUT_HDR.dst_addr == `BB_MCAST_ADDR &&
		OUT_HDR.dst_port >= `BB_PORT_BASE &&
		OUT_HDR.dst_port <= `BB_PORT_BASE + 16'h003f) // see [R2]
		else $error("Destination address or port wrong");
	AST_MARKER_CONT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		head_go && !first_pkt |=> !OUT_HDR.marker) // see [R3]
		else $error("Marker set on continuation packet");
	AST_TS_STABLE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		head_go && !first_pkt |=> $stable(OUT_HDR.timestamp)) // see [R4]
		else $error("Timestamp changed within a set");
	AST_SSRC: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		OUT_VALID |-> (OUT_HDR.marker || OUT_HDR.ssrc == 32'h0)) // see [R5]
		else $error("SSRC not zero on continuation packet");
	AST_PTYPE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		OUT_VALID |-> OUT_HDR.payload_type == 7'h4e &&
		OUT_HDR.csrc_count == 4'h0) // see [R6] see [R7]
		else $error("Payload type or CSRC count wrong");
	AST_EXT: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		head_go |=> OUT_HDR.extension == $past(desc_q.signed_ext)) // see [R8]
		else $error("Extension bit does not follow signing");
	AST_LAST: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		pkt_end |=> OUT_VALID && OUT_BEAT.last) // see [R10]
		else $error("Packet end not marked on output");
	AST_MTU: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		OUT_VALID |-> OUT_HDR.payload_len != 16'h0 &&
		OUT_HDR.payload_len <= `BB_PAY_PLAIN) // see [R11]
		else $error("Packet payload exceeds MTU room");
	AST_NS_RANGE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		state != bb_seg_pkg::ST_IDLE |-> desc_q.nanosec <= `BB_NS_MAX)
		else $error("Nanoseconds out of range"); // see [R15]
	AST_SEQ: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		head_go |=> OUT_HDR.seq_num == $past(cur_seq) &&
		seq_tab[$past(desc_q.pipe)] == $past(cur_seq) + 16'h0001)
		else $error("Sequence number did not advance by one"); // see [R17]

endmodule : baseband_rtp_segmenter

// File: hdl/bb_seg_regs.svh
// Constants for the baseband RTP segmenter: addresses, fields, sizes
`ifndef BB_SEG_REGS_SVH
`define BB_SEG_REGS_SVH

// ----------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------
`define BB_MCAST_ADDR 32'hef003330
`define BB_PORT_BASE 16'h7530
`define BB_PIPE_MAX 6'h3f

// ----------------------------------------------------------------
// RTP header field values
// ----------------------------------------------------------------
`define BB_RTP_VERSION 2'h2
`define BB_PAYLOAD_TYPE 7'h4e
`define BB_CSRC_COUNT 4'h0
`define BB_PADDING 1'h0

// ----------------------------------------------------------------
// Frame time fields
// ----------------------------------------------------------------
`define BB_SEC_BITS 22
`define BB_NS_HI 29
`define BB_NS_LO 20
`define BB_NS_MAX 32'h3b9ac9ff

// ----------------------------------------------------------------
// Packet sizes in bytes
// ----------------------------------------------------------------
`define BB_MTU 16'h05dc
`define BB_IP_HDR 16'h0014
`define BB_UDP_HDR 16'h0008
`define BB_RTP_HDR 16'h000c
`define BB_EXT_HDR 16'h0014
`define BB_PAY_PLAIN (`BB_MTU - `BB_IP_HDR - `BB_UDP_HDR - `BB_RTP_HDR)
`define BB_PAY_SIGNED (`BB_PAY_PLAIN - `BB_EXT_HDR)

`endif

// File: hdl/bb_seg_pkg.sv
// Types shared by the baseband RTP segmenter
package bb_seg_pkg;

	// ------------------------------------------------------------
	// Descriptor of one complete baseband structure
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] length;
		logic [31:0] seconds;
		logic [31:0] nanosec;
		logic [5:0] pipe;
		logic signed_ext;
	} desc_t;

	// ------------------------------------------------------------
	// Header of one emitted multicast packet
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] dst_addr;
		logic [15:0] dst_port;
		logic [1:0] version;
		logic padding;
		logic extension;
		logic [3:0] csrc_count;
		logic marker;
		logic [6:0] payload_type;
		logic [15:0] seq_num;
		logic [31:0] timestamp;
		logic [31:0] ssrc;
		logic [15:0] payload_len;
	} hdr_t;

	// ------------------------------------------------------------
	// One payload byte on the output stream
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic first;
		logic last;
	} beat_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HEAD = 2'b01,
		ST_DATA = 2'b10
	} seg_state_t;

endpackage : bb_seg_pkg

// File: verif/bb_consumer_model.sv
// Far-side consumer model: takes payload bytes, reassembles structures
`timescale 1ns/100ps
module bb_consumer_model (
	input wire logic clk, // System clock
	input wire logic rst_n, // Reset, active low
	input wire logic stall, // Hold off taking bytes
	input wire logic out_valid, // Payload byte offered
	input wire bb_seg_pkg::beat_t beat, // Payload byte
	input wire bb_seg_pkg::hdr_t hdr, // Packet header
	output logic out_ready, // Byte taken when high
	output logic [7:0] n_sets, // Structures completed
	output logic [7:0] n_lost // Structures discarded
);
	bb_seg_pkg::hdr_t hq[$];
	bb_seg_pkg::beat_t dq[$];
	logic [31:0] target;
	logic [31:0] acc;
	logic [15:0] next_seq;
	logic busy;

	// ------------------------------------------------------------
	// Taking bytes and rebuilding structures
	// ------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_ready <= 1'b0;
			n_sets <= 8'h00;
			n_lost <= 8'h00;
			busy = 1'b0;
			acc = 32'h0;
			target = 32'h0;
			next_seq = 16'h0000;
		end else begin
			if (out_valid && out_ready) begin
				dq.push_back(beat);
				if (beat.first) begin
					hq.push_back(hdr);
					if (hdr.marker) begin
						if (busy) n_lost <= n_lost + 8'h01;
						busy = 1'b1;
						target = hdr.ssrc;
						acc = 32'h0;
					end else if (hdr.seq_num !== next_seq) begin
						if (busy) n_lost <= n_lost + 8'h01;
						busy = 1'b0;
					end
					next_seq = hdr.seq_num + 16'h0001;
				end
				if (busy) begin
					acc = acc + 32'h1;
					if (acc == target) begin
						n_sets <= n_sets + 8'h01;
						busy = 1'b0;
					end
				end
			end
			out_ready <= !stall;
		end
	end
endmodule : bb_consumer_model

// File: verif/tb.sv
// Self-checking testbench of the baseband RTP segmenter
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checks_done++; \
	if ((got) !== (exp)) begin n_errors++; \
	$display("BAD %s exp %0h got %0h", what, exp, got); end end
module tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic desc_valid = 1'b0;
	bb_seg_pkg::desc_t desc = '0;
	logic in_valid = 1'b0;
	logic [7:0] in_data = 8'h00;
	logic stall = 1'b0;
	logic desc_ready, in_ready, out_valid, out_ready;
	bb_seg_pkg::beat_t out_beat;
	bb_seg_pkg::hdr_t out_hdr;
	logic [7:0] n_sets, n_lost;
	logic [15:0] seq [64] = '{default: 16'h0000};
	int n_errors = 0;
	int checks_done = 0;

	baseband_rtp_segmenter baseband_rtp_segmenter_inst (.SYS_CLK(clk),
		.ARST_N(arst_n), .DESC_VALID(desc_valid), .DESC(desc),
		.DESC_READY(desc_ready), .IN_VALID(in_valid), .IN_DATA(in_data),
		.IN_READY(in_ready), .OUT_VALID(out_valid), .OUT_BEAT(out_beat),
		.OUT_READY(out_ready), .OUT_HDR(out_hdr));
	bb_consumer_model bb_consumer_model_inst (.clk(clk), .rst_n(arst_n),
		.stall(stall), .out_valid(out_valid), .beat(out_beat),
		.hdr(out_hdr), .out_ready(out_ready), .n_sets(n_sets),
		.n_lost(n_lost));

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial forever #12.5 clk = ~clk;
	initial begin
		#500000;
		n_errors++;
		complete_run();
	end

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic send_desc(input bb_seg_pkg::desc_t d);
		desc_valid <= 1'b1;
		desc <= d;
		do @(posedge clk); while (desc_ready !== 1'b1);
		desc_valid <= 1'b0;
	endtask : send_desc

	task automatic feed(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			in_valid <= 1'b1;
			in_data <= base + i[7:0];
			do @(posedge clk); while (in_ready !== 1'b1);
		end
		in_valid <= 1'b0;
	endtask : feed

	// ------------------------------------------------------------
	// One structure: send, collect, compare headers and bytes
	// ------------------------------------------------------------
	task automatic run_set(input int len, input logic [5:0] pipe,
		input logic sgn, input logic [31:0] sec, input logic [31:0] ns,
		input logic [7:0] base, input int hold);
		bb_seg_pkg::desc_t d;
		bb_seg_pkg::hdr_t e;
		bb_seg_pkg::beat_t b;
		logic [31:0] nsc;
		logic [7:0] sets0;
		int pay, off, k, w, pl;
		d = '{length: 32'(len), seconds: sec, nanosec: ns, pipe: pipe,
			signed_ext: sgn};
		nsc = (ns > 32'd999999999) ? 32'd999999999 : ns;
		pay = sgn ? 1440 : 1460;
		sets0 = n_sets;
		bb_consumer_model_inst.hq.delete();
		bb_consumer_model_inst.dq.delete();
		fork
			send_desc(d);
			feed(len, base);
			if (hold > 0) begin
				stall <= 1'b1;
				repeat (hold) @(posedge clk);
				`CHK("full", 1'b0, in_ready)
				stall <= 1'b0;
			end
		join
		w = 0;
		while (bb_consumer_model_inst.dq.size() < len && w < 8000) begin
			@(posedge clk);
			w++;
		end
		repeat (4) @(posedge clk);
		`CHK("sets", sets0 + 8'h01, n_sets)
		`CHK("lost", 8'h00, n_lost)
		`CHK("idle", 1'b1, desc_ready)
		off = 0;
		k = 0;
		while (off < len) begin
			pl = (len - off < pay) ? len - off : pay;
			e = '{dst_addr: 32'hef003330, dst_port: 16'h7530 + 16'(pipe),
				version: 2'h2, padding: 1'b0, extension: sgn,
				csrc_count: 4'h0, marker: (k == 0), payload_type: 7'h4e,
				seq_num: seq[pipe], timestamp: {sec[21:0], nsc[29:20]},
				ssrc: (k == 0) ? 32'(len) : 32'h0, payload_len: 16'(pl)};
			`CHK("hdr", e, bb_consumer_model_inst.hq[k])
			for (int i = 0; i < pl; i++) begin
				b = '{data: base + 8'(off + i), first: (i == 0),
					last: (i == pl - 1)};
				`CHK("beat", b, bb_consumer_model_inst.dq[off + i])
			end
			seq[pipe] = seq[pipe] + 16'h0001;
			off += pl;
			k++;
		end
		`CHK("npkt", k, bb_consumer_model_inst.hq.size())
	endtask : run_set

	// Zero-length descriptor yields no packets and no busy state
	task automatic zero_len();
		bb_seg_pkg::desc_t d;
		d = '0;
		d.pipe = 6'h05;
		bb_consumer_model_inst.hq.delete();
		send_desc(d);
		repeat (20) @(posedge clk);
		`CHK("zready", 1'b1, desc_ready)
		`CHK("zpkts", 0, bb_consumer_model_inst.hq.size())
	endtask : zero_len

	// ------------------------------------------------------------
	// Verdict
	// ------------------------------------------------------------
	task automatic complete_run();
		if (n_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		run_set(10, 6'h05, 1'b0, 32'h12345678, 32'd500000000, 8'h10, 0);
		run_set(3000, 6'h3f, 1'b1, 32'hfedcba98, 32'd999999999, 8'h80, 0);
		zero_len();
		run_set(40, 6'h05, 1'b0, 32'h00000001, 32'hffffffff, 8'h33, 60);
		run_set(1461, 6'h00, 1'b0, 32'h003fffff, 32'd1048576, 8'h00, 0);
		complete_run();
	end
endmodule : tb
